// file: verilog/strap_pkg.sv
package strap_pkg;

	// ==========================================================
	// Register map (byte addresses on APB)
	// ==========================================================
	localparam logic [7:0] ADDR_STRAP_STATUS = 8'h00; // Captured bits, RO
	localparam logic [7:0] ADDR_BOOT_CTRL    = 8'h04; // Overrides, RW
	localparam logic [7:0] ADDR_BOOT_STATUS  = 8'h08; // Effective settings

	// ==========================================================
	// Strap bit positions in the captured vector
	// ==========================================================
	localparam int STRAP_W       = 5;
	localparam int BIT_LDO       = 0; // Regulator voltage strap
	localparam int BIT_BOOT_SEL  = 1; // Boot select strap
	localparam int BIT_DL_QUAL   = 2; // Download qualify strap
	localparam int BIT_LOG_SDIO  = 3; // Log and SDIO input-edge strap
	localparam int BIT_SDIO_EDGE = 4; // SDIO output-edge strap

	// Weak pull direction per strap: 1 = pull-up, 0 = pull-down
	localparam logic [4:0] STRAP_PULL_UP = 5'h1A;
	// Strap latch value before any capture (equals pull levels)
	localparam logic [4:0] STRAP_RST     = 5'h1A;

	// ==========================================================
	// Control register fields
	// ==========================================================
	localparam int CTRL_LDO_OVR_EN  = 0; // Use software voltage select
	localparam int CTRL_LDO_OVR_VAL = 1; // 1 = 1.8 V, 0 = 3.3 V
	localparam int CTRL_SDIO_OVR_EN = 2; // Use software edge select
	localparam int CTRL_SDIO_IN_R   = 3; // Input on rising edge
	localparam int CTRL_SDIO_OUT_R  = 4; // Output on rising edge
	localparam int CTRL_LDO_OFF     = 5; // Switch regulator off
	localparam int CTRL_W           = 6;
	localparam logic [5:0] CTRL_RST = 6'h00;

	// Boot source encoding
	typedef enum logic [1:0] {
		BOOT_FLASH    = 2'b00,
		BOOT_DOWNLOAD = 2'b01,
		BOOT_UNDEF    = 2'b10
	} boot_src_t;

	// Decoded boot settings travel together
	typedef struct packed {
		logic      ldo_1v8;     // Regulator at 1.8 V
		logic      ldo_enable;  // Regulator on
		boot_src_t boot_src;    // Selected boot source
		logic      log_enable;  // Boot log on serial transmit
		logic      sdio_in_r;   // SDIO samples on rising edge
		logic      sdio_out_r;  // SDIO launches on rising edge
	} boot_cfg_t;

endpackage : strap_pkg

// file: verilog/reset_strap_latch_and_decode.sv
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/100ps
module reset_strap_latch_and_decode
	import strap_pkg::*;
(
	// APB clock and reset
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	// System reset in progress (power-on, watchdog, brownout)
	input  wire logic                      sys_reset_active,
	// APB slave
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [7:0]                paddr,
	input  wire logic [31:0]               pwdata,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	// Strap pins (sampled from pads)
	input  wire logic                      ldo_voltage_strap_pin,
	input  wire logic                      boot_select_strap_pin,
	input  wire logic                      download_qualify_strap_pin,
	input  wire logic                      log_and_sdio_strap_pin,
	input  wire logic                      sdio_edge_strap_pin,
	// Pad pull control
	output logic      [strap_pkg::STRAP_W-1:0] pull_up_en,
	output logic      [strap_pkg::STRAP_W-1:0] pull_down_en,
	output logic                           strap_pad_owned,
	// Decoded settings
	output strap_pkg::boot_cfg_t           boot_cfg,
	output logic                           boot_log_serial_tx_en
);
	import strap_pkg::*;

	// ==========================================================
	// Pin synchronisers
	// ==========================================================
	logic [STRAP_W-1:0] pin_meta_ff;  // First stage, read by stage two only
	logic [STRAP_W-1:0] pin_sync_ff;  // Second stage
	logic               rst_meta_ff;  // Reset-active level, stage one
	logic               rst_sync_ff;  // Reset-active level, stage two
	logic               rst_prev_ff;  // Delayed copy for edge detect
	wire  [STRAP_W-1:0] pins_raw;

	assign pins_raw = {sdio_edge_strap_pin, log_and_sdio_strap_pin,
		download_qualify_strap_pin, boot_select_strap_pin,
		ldo_voltage_strap_pin};

	// Pads and the reset-active level come from outside this clock,
	// so nothing reads them before the second flop has settled.
	// Two flops for pad levels and for the reset-active level
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pin_meta_ff <= STRAP_RST;
			pin_sync_ff <= STRAP_RST;
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= 1'b1;
			rst_prev_ff <= 1'b1;
		end
		else
		begin
			pin_meta_ff <= pins_raw;
			pin_sync_ff <= pin_meta_ff;
			rst_meta_ff <= sys_reset_active;
			rst_sync_ff <= rst_meta_ff;
			rst_prev_ff <= rst_sync_ff;
		end
	end

	// ==========================================================
	// Strap latch
	// ==========================================================
	logic [STRAP_W-1:0] strap_ff;      // Captured strap bits
	logic               captured_ff;   // Latch closed
	wire                in_reset;
	wire                reset_release;
	wire                capture_open;
	logic [STRAP_W-1:0] nxt_strap;

	assign in_reset      = rst_sync_ff;
	assign reset_release = rst_prev_ff & ~rst_sync_ff;
	// Track pins throughout reset, freeze on release edge
	assign capture_open  = in_reset | reset_release;
	assign nxt_strap     = capture_open ? pin_sync_ff : strap_ff;

	// Latch follows pins while reset runs; afterward only presetn
	// (power down) or a new system reset can disturb it, so later pin toggles are ignored.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			strap_ff    <= STRAP_RST;
			captured_ff <= 1'b0;
		end
		else
		begin
			strap_ff    <= nxt_strap;
			captured_ff <= captured_ff | reset_release;
		end
	end

	// ==========================================================
	// Pad pulls and ownership
	// ==========================================================
	// Pulls only while reset holds; a floating pad then reads the
	// pull level, so the latch takes that value.
	assign pull_up_en      = in_reset ? STRAP_PULL_UP : '0;
	assign pull_down_en    = in_reset ? ~STRAP_PULL_UP : '0;
	// Pads handed back to their normal function after reset
	assign strap_pad_owned = in_reset;

	// ==========================================================
	// APB registers
	// ==========================================================
	logic [CTRL_W-1:0] ctrl_ff;       // Override and power controls
	logic [31:0]       prdata_ff;     // Registered read data
	wire               apb_access;
	wire               wr_ctrl;
	wire               addr_hit;
	wire  [31:0]       rd_mux;

	assign apb_access = psel & penable;
	assign addr_hit   = (paddr == ADDR_STRAP_STATUS) |
		(paddr == ADDR_BOOT_CTRL) | (paddr == ADDR_BOOT_STATUS);
	// Write lands on the completing access edge, so the register
	// changes on the same edge at which the master sees pready.
	assign wr_ctrl    = apb_access & pready & pwrite &
		(paddr == ADDR_BOOT_CTRL);

	// Zero-wait slave: access phase completes at once
	assign pready  = 1'b1;
	assign pslverr = apb_access & ~addr_hit;
	assign prdata  = prdata_ff;

	// Read mux; strap register has no write path
	assign rd_mux =
		(paddr == ADDR_STRAP_STATUS) ? {27'h0, strap_ff} :
		(paddr == ADDR_BOOT_CTRL)    ? {26'h0, ctrl_ff}  :
		(paddr == ADDR_BOOT_STATUS)  ? {24'h0, boot_cfg, captured_ff} :
		32'h0;

	// Read data latched during setup, so the access-phase edge
	// already presents it; it then stands until the next read
	// setup. Writes wait for the access edge instead, trading the
	// early capture for a write that matches bus completion.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_ff   <= CTRL_RST;
			prdata_ff <= 32'h0;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_ff <= pwdata[CTRL_W-1:0];
			if (psel & ~penable & ~pwrite)
				prdata_ff <= rd_mux;
		end
	end

	// ==========================================================
	// Decode of boot settings
	// ==========================================================
	boot_cfg_t nxt_cfg;
	boot_src_t src;

	// Boot select high wins; both low gives download
	assign src = strap_ff[BIT_BOOT_SEL] ? BOOT_FLASH :
		(strap_ff[BIT_DL_QUAL] ? BOOT_UNDEF : BOOT_DOWNLOAD);

	always_comb
	begin
		nxt_cfg          = '0;
		// Voltage: strap unless firmware override
		nxt_cfg.ldo_1v8  = ctrl_ff[CTRL_LDO_OVR_EN] ?
			ctrl_ff[CTRL_LDO_OVR_VAL] : strap_ff[BIT_LDO];
		// Software power-off of the regulator
		nxt_cfg.ldo_enable = ~ctrl_ff[CTRL_LDO_OFF];
		nxt_cfg.boot_src   = src;
		nxt_cfg.log_enable = strap_ff[BIT_LOG_SDIO];
		// Edges: {log, edge} = {in rising, out rising}
		if (ctrl_ff[CTRL_SDIO_OVR_EN])
		begin
			nxt_cfg.sdio_in_r  = ctrl_ff[CTRL_SDIO_IN_R];
			nxt_cfg.sdio_out_r = ctrl_ff[CTRL_SDIO_OUT_R];
		end
		else
		begin
			nxt_cfg.sdio_in_r  = strap_ff[BIT_LOG_SDIO];
			nxt_cfg.sdio_out_r = strap_ff[BIT_SDIO_EDGE];
		end
	end

	// Outputs from flops; one cycle behind the latch
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			boot_cfg              <= '0;
			boot_log_serial_tx_en <= 1'b0;
		end
		else
		begin
			boot_cfg              <= nxt_cfg;
			boot_log_serial_tx_en <= nxt_cfg.log_enable;
		end
	end

	// ==========================================================
	// Assertions
	// ==========================================================
	// Checks on flopped outputs skip the release edge itself: the
	// flops still hold their reset values one edge after it.
	a_strap_hold: assert property (@(posedge pclk)
		disable iff (!presetn)
		(!rst_sync_ff && !rst_prev_ff) |=> $stable(strap_ff))
		else $error("strap latch changed after reset");
	a_strap_take: assert property (@(posedge pclk)
		disable iff (!presetn)
		rst_sync_ff |=> strap_ff == $past(pin_sync_ff))
		else $error("strap latch missed pin level");
	a_release_final: assert property (@(posedge pclk)
		disable iff (!presetn)
		reset_release |=> strap_ff == $past(pin_sync_ff) ##1
		$stable(strap_ff))
		else $error("latch not final at release");
	a_pull_dir: assert property (@(posedge pclk)
		disable iff (!presetn)
		in_reset |-> pull_up_en == 5'h1A && pull_down_en == 5'h05)
		else $error("wrong pull direction");
	a_pads_free: assert property (@(posedge pclk)
		disable iff (!presetn)
		!in_reset |-> !strap_pad_owned && pull_up_en == 5'h00 &&
		pull_down_en == 5'h00)
		else $error("pads held after reset");
	a_ldo_select: assert property (@(posedge pclk)
		disable iff (!presetn)
		presetn && !ctrl_ff[CTRL_LDO_OVR_EN]
		|=> boot_cfg.ldo_1v8 == $past(strap_ff[BIT_LDO]))
		else $error("regulator voltage wrong");
	a_ldo_ovr: assert property (@(posedge pclk)
		disable iff (!presetn)
		ctrl_ff[CTRL_LDO_OVR_EN]
		|=> boot_cfg.ldo_1v8 == $past(ctrl_ff[CTRL_LDO_OVR_VAL]))
		else $error("regulator override ignored");
	a_boot_mode: assert property (@(posedge pclk)
		disable iff (!presetn)
		presetn && !strap_ff[BIT_BOOT_SEL] && !strap_ff[BIT_DL_QUAL]
		|=> boot_cfg.boot_src == BOOT_DOWNLOAD)
		else $error("download boot not chosen");
	a_flash_boot: assert property (@(posedge pclk)
		disable iff (!presetn)
		presetn && strap_ff[BIT_BOOT_SEL]
		|=> boot_cfg.boot_src == BOOT_FLASH)
		else $error("flash boot not chosen");
	a_log_pin: assert property (@(posedge pclk)
		disable iff (!presetn)
		presetn |=> boot_log_serial_tx_en ==
		$past(strap_ff[BIT_LOG_SDIO]))
		else $error("boot log enable wrong");
	a_sdio_edge: assert property (@(posedge pclk)
		disable iff (!presetn)
		presetn && !ctrl_ff[CTRL_SDIO_OVR_EN]
		|=> {boot_cfg.sdio_in_r, boot_cfg.sdio_out_r} ==
		{$past(strap_ff[BIT_LOG_SDIO]), $past(strap_ff[BIT_SDIO_EDGE])})
		else $error("sdio edge select wrong");
	a_ovr_wins: assert property (@(posedge pclk)
		disable iff (!presetn)
		ctrl_ff[CTRL_SDIO_OVR_EN]
		|=> {boot_cfg.sdio_in_r, boot_cfg.sdio_out_r} ==
		{$past(ctrl_ff[CTRL_SDIO_IN_R]), $past(ctrl_ff[CTRL_SDIO_OUT_R])})
		else $error("sdio override ignored");
	a_ldo_off: assert property (@(posedge pclk)
		disable iff (!presetn)
		ctrl_ff[CTRL_LDO_OFF] |=> !boot_cfg.ldo_enable)
		else $error("regulator not switched off");
	a_ldo_on: assert property (@(posedge pclk)
		disable iff (!presetn)
		presetn && !ctrl_ff[CTRL_LDO_OFF] |=> boot_cfg.ldo_enable)
		else $error("regulator switched off unasked");
	a_ctrl_write: assert property (@(posedge pclk)
		disable iff (!presetn)
		psel && penable && pwrite && paddr == ADDR_BOOT_CTRL
		|=> ctrl_ff == $past(pwdata[CTRL_W-1:0]))
		else $error("control write lost");
	a_status_read: assert property (@(posedge pclk)
		disable iff (!presetn)
		psel && !penable && !pwrite && paddr == ADDR_STRAP_STATUS
		|=> prdata == {27'h0, $past(strap_ff)})
		else $error("strap status read wrong");

endmodule : reset_strap_latch_and_decode

// file: verif/strap_pad_model.sv
`timescale 1ns/100ps
// ========================================
// Board side of the strap pins
// ========================================
module strap_pad_model
(
	// Clock for the wander pattern
	input  wire logic       pclk,
	// Host outputs driving the pins
	input  wire logic [4:0] host_en,
	input  wire logic [4:0] host_val,
	// Device weak pulls
	input  wire logic [4:0] pull_up_en,
	input  wire logic [4:0] pull_down_en,
	// Resolved pad levels
	output logic      [4:0] pad
);
	logic [4:0] wobble_ff = 5'h15; // Level of an undriven line
	// A line with no driver and no pull must never look stable
	always @(posedge pclk)
	begin
		wobble_ff <= ~wobble_ff;
	end
	// Host drive wins, then the device pull, else wander
	always_comb
	begin
		for (int i = 0; i < 5; i++)
			pad[i] = host_en[i] ? host_val[i] :
				pull_up_en[i] ? 1'b1 :
				pull_down_en[i] ? 1'b0 : wobble_ff[i];
	end
endmodule : strap_pad_model

// file: verif/tb_reset_strap_latch_and_decode.sv
`timescale 1ns/100ps
module tb_reset_strap_latch_and_decode;
	import strap_pkg::*;
	// ========================================
	// Signals
	// ========================================
	logic        pclk, presetn, sys_reset_active;
	logic        psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [4:0]  pad, host_en, host_val, pull_up_en, pull_down_en;
	logic        strap_pad_owned, tx_en;
	boot_cfg_t   cfg;
	logic [5:0]  ctl [6] = '{6'h03, 6'h01, 6'h04, 6'h14, 6'h0C, 6'h20};
	int          err_total = 0;
	int          checks = 0;
	int          cyc = 0;
	// Chip enable low time and rail settle time: 50 us of 4 ns cycles
	localparam int CE_LOW_CYC = 12500;
	// ========================================
	// Design and pad model
	// ========================================
	reset_strap_latch_and_decode u_reset_strap_latch_and_decode (
		.pclk(pclk), .presetn(presetn),
		.sys_reset_active(sys_reset_active),
		.psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr),
		.ldo_voltage_strap_pin(pad[0]),
		.boot_select_strap_pin(pad[1]),
		.download_qualify_strap_pin(pad[2]),
		.log_and_sdio_strap_pin(pad[3]),
		.sdio_edge_strap_pin(pad[4]),
		.pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
		.strap_pad_owned(strap_pad_owned), .boot_cfg(cfg),
		.boot_log_serial_tx_en(tx_en));
	strap_pad_model u_strap_pad_model (
		.pclk(pclk), .host_en(host_en), .host_val(host_val),
		.pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
		.pad(pad));
	// ========================================
	// Helpers
	// ========================================
	// Compare and count
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("FAIL %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// One APB transfer; waits on pready, never on a fixed count
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Host drives the straps through a full system reset
	task automatic strap_boot(input logic [4:0] v);
		host_en <= 5'h1F;
		host_val <= v;
		sys_reset_active <= 1'b1;
		repeat (8) @(posedge pclk);
		sys_reset_active <= 1'b0;
		repeat (8) @(posedge pclk);
	endtask : strap_boot
	// Settings worked out from captured bits and control word
	function automatic logic [6:0] exp_cfg(logic [4:0] s, logic [5:0] c);
		logic [1:0] src;
		src = s[BIT_BOOT_SEL] ? 2'b00 : s[BIT_DL_QUAL] ? 2'b10 : 2'b01;
		return {c[0] ? c[1] : s[BIT_LDO], ~c[5], src, s[BIT_LOG_SDIO],
			c[2] ? c[3] : s[3], c[2] ? c[4] : s[4]};
	endfunction : exp_cfg
	// Verdict in one place
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : stop_test
	// ========================================
	// Clock and timeout
	// ========================================
	initial
	begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	// Whole run needs about 13300 cycles, most of it the power cycle
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_total++;
			stop_test();
		end
	end
	// ========================================
	// Tests
	// ========================================
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		sys_reset_active = 1'b1;
		host_en = 5'h00;
		host_val = 5'h00;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		// Floating pins during reset take the weak pulls
		repeat (6) @(posedge pclk);
		chk("pull_up", pull_up_en, 5'h1A);
		chk("pull_dn", pull_down_en, 5'h05);
		chk("owned", strap_pad_owned, 1'b1);
		sys_reset_active <= 1'b0;
		repeat (8) @(posedge pclk);
		chk("pull_rel", {pull_up_en, pull_down_en}, 10'h000);
		chk("own_rel", strap_pad_owned, 1'b0);
		apb(1'b0, ADDR_STRAP_STATUS, 32'h0);
		chk("float", rd, 32'h1A);
		chk("cfg_f", cfg, exp_cfg(5'h1A, 6'h00));
		$display("test pulls done");
		// Every strap pattern, then pins move after capture
		for (int v = 0; v < 32; v++)
		begin
			strap_boot(v[4:0]);
			host_val <= ~v[4:0];
			repeat (4) @(posedge pclk);
			apb(1'b0, ADDR_STRAP_STATUS, 32'h0);
			chk("strap", rd, v);
			chk("cfg", cfg, exp_cfg(v[4:0], 6'h00));
			chk("tx_en", tx_en, v[3]);
		end
		$display("test sweep done");
		// Firmware overrides and regulator off
		for (int i = 0; i < 6; i++)
		begin
			apb(1'b1, ADDR_BOOT_CTRL, {26'h0, ctl[i]});
			apb(1'b0, ADDR_BOOT_CTRL, 32'h0);
			chk("ctrl", rd, {26'h0, ctl[i]});
			repeat (2) @(posedge pclk);
			chk("ovr", cfg, exp_cfg(5'h1F, ctl[i]));
		end
		$display("test override done");
		// Captured bits cannot be written; unmapped place refused
		apb(1'b1, ADDR_STRAP_STATUS, 32'h0);
		apb(1'b0, ADDR_STRAP_STATUS, 32'h0);
		chk("ro", rd, 32'h1F);
		apb(1'b0, 8'h0C, 32'h0);
		chk("unmap", {err, rd}, {1'b1, 32'h0});
		$display("test access done");
		// Power cycle: latch and control cleared, straps taken anew
		@(posedge pclk);
		presetn <= 1'b0;
		sys_reset_active <= 1'b1;
		host_val <= 5'h05;
		repeat (CE_LOW_CYC) @(posedge pclk);
		presetn <= 1'b1;
		strap_boot(5'h05);
		apb(1'b0, ADDR_STRAP_STATUS, 32'h0);
		chk("pwr_strap", rd, 32'h05);
		apb(1'b0, ADDR_BOOT_STATUS, 32'h0);
		chk("pwr_stat", rd, {exp_cfg(5'h05, 6'h00), 1'b1});
		$display("test power cycle done");
		stop_test();
	end
endmodule : tb_reset_strap_latch_and_decode
